/* logic_source.sv */
`timescale 1ns/1ns
module logic_source (
  // bench commands
  input wire logic [2:0] cmd,
  // logic inputs of the relay
  output logic trigger,
  output logic set_in,
  output logic clear_in
);
  // plain levels: upstream blocks have no glitch filter either
  assign {trigger, set_in, clear_in} = cmd;
endmodule

/* relay_defs.svh */
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH

// output state after a cold start without retention
`define RELAY_INIT_STATE 1'h0
// variant selection codes
`define VARIANT_LATCH 2'h0
`define VARIANT_TOGGLE 2'h1
`define VARIANT_LEGACY 2'h2
// priority selection codes
`define PRIO_CLEAR_DOMINANT 1'h0
`define PRIO_FORCE_ON_DOMINANT 1'h1

`endif

/* relay_pkg.sv */
package relay_pkg;
  typedef enum logic [1:0] {
    var_latch,
    var_toggle,
    var_legacy
  } variant_t;
endpackage

/* set_reset_toggle_relay.sv */
// Operation
// - latch mode: set drives output high, stays high until clear
// - latch mode: set and clear together give low output
// - latch mode: no inputs active holds the previous output
// - with retention, latch and toggle output after power return equals pre-failure value
// - toggle mode: trigger rising edge inverts output when set and clear low
// - toggle mode: trigger ignored while set or clear high
// - toggle mode: set forces one unless dominant clear is high
// - toggle mode: clear forces zero unless dominant set is high
// - priority setting picks which of set or clear dominates in toggle mode
// - legacy toggle: no set, no priority; trigger toggles, clear turns off
// - legacy toggle: output zero at power-on and on clear
`timescale 1ns/1ns
`include "relay_defs.svh"

module set_reset_toggle_relay (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration
  input wire logic [1:0] variant_sel,
  input wire logic force_on_dominant,
  input wire logic retain_en,
  input wire logic retained_state,
  // logic inputs
  input wire logic trigger,
  input wire logic set_in,
  input wire logic clear_in,
  // relay output
  output logic relay_out
);

  logic trig_q;
  logic state_q;
  logic state_d;
  logic restore_q;
  logic relay_out_q;

  wire relay_pkg::variant_t variant = relay_pkg::variant_t'(variant_sel);
  wire trig_rise = trigger & ~trig_q;
  wire idle_inputs = ~set_in & ~clear_in;
  // legacy variant has no set input and no priority option
  wire set_eff = (variant == relay_pkg::var_legacy) ? 1'h0 : set_in;
  wire clear_wins = (force_on_dominant == `PRIO_CLEAR_DOMINANT) | ~set_eff;
  wire set_wins = (force_on_dominant == `PRIO_FORCE_ON_DOMINANT) | ~clear_in;

  wire latch_next = clear_in ? 1'h0 : (set_in ? 1'h1 : state_q);
  wire toggle_next =
    (clear_in & clear_wins) ? 1'h0 :
    (set_eff & set_wins) ? 1'h1 :
    (trig_rise & ~set_eff & ~clear_in) ? ~state_q : state_q;
  wire legacy_next = clear_in ? 1'h0 : (trig_rise ? ~state_q : state_q);

  always_comb begin
    case (variant)
      relay_pkg::var_latch: state_d = latch_next;
      relay_pkg::var_toggle: state_d = toggle_next;
      relay_pkg::var_legacy: state_d = legacy_next;
      default: state_d = state_q;
    endcase
  end

  // restore happens on the first clock after release, since async reset takes constants only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      restore_q <= 1'h1;
    end else begin
      restore_q <= 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trig_q <= 1'h1; // a level already high at start is not an edge
    end else begin
      trig_q <= trigger;
    end
  end

  // legacy variant always starts cleared; the backed-up value is ignored there
  wire restore_val = retain_en & (variant != relay_pkg::var_legacy) & retained_state;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= `RELAY_INIT_STATE;
    end else if (restore_q) begin
      state_q <= restore_val;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      relay_out_q <= `RELAY_INIT_STATE;
    end else if (restore_q) begin
      relay_out_q <= restore_val;
    end else begin
      relay_out_q <= state_d;
    end
  end

  assign relay_out = relay_out_q;

  // assertions
  sequence set_only_s;
    set_in && !clear_in && !restore_q;
  endsequence

  latch_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_latch) and set_only_s |=> relay_out)
    else $error("latch set did not raise output");

  latch_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_latch) && clear_in && !restore_q |=> !relay_out)
    else $error("latch clear did not lower output");

  latch_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_latch) && idle_inputs && !restore_q
      |=> relay_out == $past(relay_out))
    else $error("latch did not hold");

  toggle_flip_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && trig_rise && idle_inputs && !restore_q
      |=> relay_out != $past(relay_out))
    else $error("toggle edge did not invert output");

  trig_ignored_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && !restore_q && set_in && clear_in
      |=> relay_out == $past(force_on_dominant))
    else $error("trigger or priority misbehaved with both inputs high");

  toggle_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) and set_only_s |=> relay_out)
    else $error("toggle set did not force one");

  toggle_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && clear_in && !set_in && !restore_q |=> !relay_out)
    else $error("toggle clear did not force zero");

  legacy_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_legacy) && clear_in && !restore_q |=> !relay_out)
    else $error("legacy clear did not force zero");

  restore_a: assert property (@(posedge mclk) disable iff (!resetn)
    restore_q |=> relay_out == $past(restore_val))
    else $error("restore value wrong after reset");

  // steps of multi-cycle checks; each excludes the restore edge
  sequence latch_idle_s;
    (variant == relay_pkg::var_latch) && idle_inputs && !restore_q;
  endsequence

  sequence toggle_edge_s;
    (variant == relay_pkg::var_toggle) && trig_rise && idle_inputs && !restore_q;
  endsequence

  sequence toggle_quiet_s;
    (variant == relay_pkg::var_toggle) && !trig_rise && idle_inputs && !restore_q;
  endsequence

  sequence legacy_edge_s;
    (variant == relay_pkg::var_legacy) && trig_rise && !clear_in && !restore_q;
  endsequence

  latch_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    ((variant == relay_pkg::var_latch) and set_only_s) ##1 latch_idle_s
      |=> relay_out)
    else $error("latch output dropped without clear");

  toggle_twice_a: assert property (@(posedge mclk) disable iff (!resetn)
    toggle_edge_s ##1 toggle_quiet_s ##1 toggle_edge_s
      |=> relay_out == $past(relay_out, 3))
    else $error("two trigger edges did not restore output");

  toggle_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    toggle_quiet_s |=> relay_out == $past(relay_out))
    else $error("toggle output moved without an edge");

  trig_blocked_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && trig_rise && (set_in || clear_in) && !restore_q
      |=> relay_out == $past(set_in && (!clear_in || force_on_dominant)))
    else $error("trigger edge acted while set or clear high");

  set_priority_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && set_in && clear_in && force_on_dominant
      && !restore_q |=> relay_out)
    else $error("dominant set did not win");

  clear_priority_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && set_in && clear_in && !force_on_dominant
      && !restore_q |=> !relay_out)
    else $error("dominant clear did not win");

  level_high_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && trigger && $past(trigger) && idle_inputs
      && !restore_q |=> relay_out == $past(relay_out))
    else $error("steady high trigger taken as an edge");

  rise_edge_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_toggle) && trigger && !$past(trigger) && idle_inputs
      && !restore_q |=> relay_out != $past(relay_out))
    else $error("trigger rise versus last level missed");

  legacy_flip_a: assert property (@(posedge mclk) disable iff (!resetn)
    legacy_edge_s |=> relay_out != $past(relay_out))
    else $error("legacy edge did not invert output");

  legacy_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (variant == relay_pkg::var_legacy) && !trig_rise && !clear_in && !restore_q
      |=> relay_out == $past(relay_out))
    else $error("legacy output moved without edge or clear");

  cold_start_a: assert property (@(posedge mclk) disable iff (!resetn)
    restore_q && !retain_en |=> !relay_out)
    else $error("output not cleared after reset");

  legacy_start_a: assert property (@(posedge mclk) disable iff (!resetn)
    restore_q && (variant == relay_pkg::var_legacy) |=> !relay_out)
    else $error("legacy output not zero at power-on");

  retain_a: assert property (@(posedge mclk) disable iff (!resetn)
    restore_q && retain_en && (variant != relay_pkg::var_legacy)
      |=> relay_out == $past(retained_state))
    else $error("retained value not restored");

endmodule

/* set_reset_toggle_relay_bench.sv */
`timescale 1ns/1ns
module set_reset_toggle_relay_bench;
  logic mclk = 0, resetn = 0, fod = 0, ret = 0, rst_st = 0, tg, st, cl, out_q;
  logic [1:0] vsel = 0;
  logic [2:0] cmd = 0;
  logic first = 1, ptrg = 1, q, nq;
  logic exp_q[$];
  int err_count = 0, n_compared = 0;
  initial begin
    forever #10 mclk = ~mclk;
  end
  logic_source src_u (.cmd(cmd), .trigger(tg), .set_in(st), .clear_in(cl));
  set_reset_toggle_relay dut_u (.mclk(mclk), .resetn(resetn), .variant_sel(vsel),
    .force_on_dominant(fod), .retain_en(ret), .retained_state(rst_st),
    .trigger(tg), .set_in(st), .clear_in(cl), .relay_out(out_q));
  // reference model, noted at each sampling edge
  always @(posedge mclk) begin
    if (!resetn) begin
      first = 1;
      ptrg = 1;
    end else begin
      nq = q ^ (tg & ~ptrg);
      if (first) q = ret & rst_st & (vsel != 2'h2);
      else if (vsel == 2'h0) q = cl ? 1'h0 : (st | q);
      else if (vsel == 2'h1) q = (st & cl) ? fod : cl ? 1'h0 : st ? 1'h1 : nq;
      else if (vsel == 2'h2) q = cl ? 1'h0 : nq;
      first = 0;
      ptrg = tg;
      exp_q.push_back(q);
    end
  end
  // result lands one edge later; skip edges swallowed by a reset
  always @(negedge mclk) begin
    if (exp_q.size() > 0) begin
      if (resetn) begin
        n_compared++;
        if (out_q !== exp_q[0]) begin
          $display("Error t=%0t got %h exp %h", $time, out_q, exp_q[0]);
          err_count++;
        end
      end
      void'(exp_q.pop_front());
    end
  end
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(10));
    for (int c = 0; c < 16; c++) begin
      @(posedge mclk);
      resetn <= 0;
      vsel <= c[1:0];
      fod <= c[2];
      ret <= c[3];
      rst_st <= 1'($urandom);
      repeat (4) @(posedge mclk);
      resetn <= 1;
      // sparse set and clear leave room for trigger edges
      repeat (80) begin
        @(posedge mclk);
        cmd <= {1'($urandom), 1'($urandom % 5 == 0), 1'($urandom % 5 == 0)};
      end
    end
    finish_test();
  end
  // about 1400 cycles expected
  initial begin
    repeat (4000) @(posedge mclk);
    err_count++;
    finish_test();
  end
endmodule
